// *** shared/lbt_pkg.sv ***
// Purpose: Constants, types and helpers of the boost target and status
//          register.
// Assumes: One byte-wide register at a single address, clk at 125 MHz.
// Notes:   Voltages are in millivolts; the comparators themselves are
//          analog and sit outside this logic.
// How it works
// R1 - Bit 4 reports regulator headroom, resets 0
// R2 - Headroom refreshed once at each strobe end
// R3 - Reading code field returns calibration result
// R4 - Written code sets boost target, resets 1001
// R5 - Code maps 3.825 V to 5.700 V, 125 mV steps
// R6 - Host changes code only after voltage mode enabled; code_q takes any write, with no mode check
// R7 - Bit 7 enables temperature monitoring, resets 0
// R8 - Bit 6 sets when sense below hot threshold
// R9 - Host writing 0 clears over-temperature flag
// R10 - Bit 5 sets when sense below warning threshold
// R11 - Reading the register clears the warning flag
// R12 - Over-temperature flag forces shutdown automatically
// R13 - Over-temperature stays latched until software clears
// R14 - Writes to read-only bits change nothing
package lbt_pkg;

	localparam int unsigned DATA_W    = 8;
	localparam int unsigned ADDR_W    = 8;
	localparam int unsigned CODE_W    = 4;
	localparam int unsigned MV_W      = 13;

	localparam logic [ADDR_W-1:0] TARGET_REG_ADDR = 8'h06;

	localparam int unsigned BIT_TEMP_EN  = 7;
	localparam int unsigned BIT_OVERTEMP = 6;
	localparam int unsigned BIT_WARN     = 5;
	localparam int unsigned BIT_HEADROOM = 4;
	localparam int unsigned CODE_LSB     = 0;
	localparam int unsigned SPARE_LSB    = 5;
	localparam int unsigned SPARE_W      = 3;

	localparam logic [CODE_W-1:0]  RESET_CODE     = 4'h9;
	localparam logic               RESET_FLAG     = 1'h0;
	localparam logic [SPARE_W-1:0] RESET_SPARE    = 3'h0;
	localparam logic [DATA_W-1:0]  UNMAPPED_RDATA = 8'h00;

	localparam int unsigned VOUT_MIN_MV  = 3825;
	localparam int unsigned VOUT_MAX_MV  = 5700;
	localparam int unsigned VOUT_STEP_MV = 125;
	localparam int unsigned TS_HOT_MV    = 345;
	localparam int unsigned TS_WARN_MV   = 1050;

	typedef enum logic [1:0] {
		FL_IDLE   = 2'b01,
		FL_STROBE = 2'b10
	} lbt_flash_t;

	// Linear code to target voltage
	function automatic logic [MV_W-1:0] lbt_code_to_mv(
		input logic [CODE_W-1:0] code
	);
		return MV_W'(VOUT_MIN_MV + VOUT_STEP_MV * int'(code)); // see R5
	endfunction : lbt_code_to_mv

	// Assemble the readable byte
	function automatic logic [DATA_W-1:0] lbt_pack(
		input logic [SPARE_W-1:0] upper,
		input logic               headroom,
		input logic [CODE_W-1:0]  code
	);
		return {upper, headroom, code};
	endfunction : lbt_pack

endpackage : lbt_pkg

// *** src/lbt_reg.sv ***
// Purpose: Boost target voltage and LED status register with headroom,
//          temperature monitor and flag handling.
// Assumes: The serial port front end presents one-cycle read and write
//          strobes with an address; flash sequencer and calibration
//          engine run on clk; comparator outputs are asynchronous.
// Notes:   THERMAL selects the variant with temperature sensing; without
//          it bits 7..5 are plain storage bits.
`timescale 1ns/1ns
`default_nettype none

module lbt_reg #(
	parameter bit          THERMAL = 1'b1,
	parameter int unsigned VCODE_W = 4
) (
	input  wire logic                          clk,
	input  wire logic                          sys_rst,
	// Register access from the serial port front end
	input  wire logic [lbt_pkg::ADDR_W-1:0]    reg_addr,
	input  wire logic                          reg_wr,
	input  wire logic [lbt_pkg::DATA_W-1:0]    reg_wdata,
	input  wire logic                          reg_rd,
	output var  logic [lbt_pkg::DATA_W-1:0]    reg_rdata,
	output var  logic                          reg_rvalid,
	// Flash sequencer, same clock
	input  wire logic                          flash_strobe,
	output var  logic                          rampdown_go,
	// Self-calibration engine, same clock
	input  wire logic                          cal_done,
	input  wire logic [lbt_pkg::CODE_W-1:0]    cal_code,
	// Analog comparators, asynchronous
	input  wire logic                          headroom_cmp,
	input  wire logic                          ts_below_warn,
	input  wire logic                          ts_below_hot,
	// Towards the power stage
	output var  logic [lbt_pkg::CODE_W-1:0]    target_voltage_code,
	output var  logic [lbt_pkg::MV_W-1:0]      target_mv,
	output var  logic                          temp_monitor_enable,
	output var  logic                          ts_bias_enable,
	output var  logic                          overtemp_flag,
	output var  logic                          temp_warning_flag,
	output var  logic                          regulator_headroom_ok,
	output var  logic                          shutdown_req,
	output var  logic                          shutdown_pulse
);

	import lbt_pkg::*;

	// Elaboration-time checks
	generate
		if (VCODE_W != CODE_W) begin : g_bad_code_w
			$error("lbt_reg serves only a 4-bit voltage code");
		end
		if (VOUT_MIN_MV + VOUT_STEP_MV * ((1 << CODE_W) - 1)
				!= VOUT_MAX_MV) begin : g_bad_scale
			$error("lbt_reg voltage scale does not close");
		end
		if (VOUT_MAX_MV >= (1 << MV_W)) begin : g_bad_mv_w
			$error("lbt_reg millivolt width too small");
		end
		// Field layout must match the packed read byte
		if (DATA_W != 8) begin : g_bad_data_w
			$error("lbt_reg serves only a byte-wide register");
		end
		if (ADDR_W < 1) begin : g_bad_addr_w
			$error("lbt_reg needs an address");
		end
		if (CODE_LSB + CODE_W != BIT_HEADROOM) begin : g_bad_code_pos
			$error("lbt_reg code field must sit below headroom bit");
		end
		if (BIT_HEADROOM + 1 != SPARE_LSB) begin : g_bad_spare_pos
			$error("lbt_reg upper field must follow headroom bit");
		end
		if (BIT_WARN != SPARE_LSB) begin : g_bad_warn_pos
			$error("lbt_reg warning bit must open upper field");
		end
		if (BIT_OVERTEMP != BIT_WARN + 1) begin : g_bad_hot_pos
			$error("lbt_reg hot bit must follow warning bit");
		end
		if (BIT_TEMP_EN != BIT_OVERTEMP + 1) begin : g_bad_en_pos
			$error("lbt_reg enable bit must follow hot bit");
		end
		if (SPARE_LSB + SPARE_W != DATA_W) begin : g_bad_spare_w
			$error("lbt_reg upper field must fill the byte");
		end
		if (CODE_W + 1 + SPARE_W != DATA_W) begin : g_bad_pack_w
			$error("lbt_reg packed fields do not fill the byte");
		end
		if (TS_HOT_MV >= TS_WARN_MV) begin : g_bad_thresholds
			$error("lbt_reg hot threshold must lie below warning");
		end
	endgenerate

	// Synchronised comparator levels
	logic [2:0] cmp_raw;
	logic [2:0] cmp_sync;
	logic       headroom_sync;
	logic       warn_sync;
	logic       hot_sync;

	// Access decode
	logic       addr_hit;
	logic       wr_hit;
	logic       rd_hit;

	// Flash strobe tracking
	lbt_flash_t flash_q;
	lbt_flash_t flash_d;
	logic       strobe_end;

	// Register contents
	logic [CODE_W-1:0]  code_q;
	logic               headroom_q;
	logic               temp_en_q;
	logic               hot_q;
	logic               warn_q;
	logic [SPARE_W-1:0] spare_q;
	logic               hot_prev_q;
	logic               rampdown_q;

	// Flag set and clear terms
	logic               mon_active;
	logic               hot_set;
	logic               hot_clr;
	logic               warn_set;
	logic               warn_clr;
	logic [SPARE_W-1:0] upper_bits;
	logic [DATA_W-1:0]  read_byte;

	assign cmp_raw = {headroom_cmp, ts_below_warn, ts_below_hot};

	lbt_sync #(
		.WIDTH    (3)
	) u_cmp_sync (
		.clk      (clk),
		.sys_rst  (sys_rst),
		.async_in (cmp_raw),
		.sync_out (cmp_sync)
	);

	assign headroom_sync = cmp_sync[2];
	assign warn_sync     = cmp_sync[1];
	assign hot_sync      = cmp_sync[0];

	assign addr_hit = (reg_addr == TARGET_REG_ADDR);
	assign wr_hit   = reg_wr & addr_hit;
	assign rd_hit   = reg_rd & addr_hit;

	// Flash strobe state: marks the single cycle at which a strobe ends
	always_comb begin
		flash_d = flash_q;
		unique case (flash_q)
			FL_IDLE: begin
				if (flash_strobe) begin
					flash_d = FL_STROBE;
				end
			end
			FL_STROBE: begin
				if (!flash_strobe) begin
					flash_d = FL_IDLE;
				end
			end
			default: begin
				flash_d = FL_IDLE;
			end
		endcase
	end

	assign strobe_end = (flash_q == FL_STROBE) & ~flash_strobe;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			flash_q <= FL_IDLE;
		end else begin
			flash_q <= flash_d;
		end
	end

	// Headroom is captured once per strobe, then held
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			headroom_q <= RESET_FLAG; // see R1
		end else if (strobe_end) begin
			headroom_q <= headroom_sync; // see R2
		end
	end

	// Ramp-down is released at the same clock edge as the headroom capture
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rampdown_q <= 1'h0;
		end else begin
			rampdown_q <= strobe_end; // see R2
		end
	end

	// Voltage code: host target, overwritten by a calibration result
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			code_q <= RESET_CODE; // see R4
		end else if (cal_done) begin
			code_q <= cal_code; // see R3
		end else if (wr_hit) begin
			code_q <= reg_wdata[CODE_LSB +: CODE_W]; // see R4
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			target_mv <= lbt_code_to_mv(RESET_CODE);
		end else begin
			target_mv <= lbt_code_to_mv(code_q); // see R5
		end
	end

	// Monitor enable exists only in the thermal variant
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			temp_en_q <= RESET_FLAG; // see R7
		end else if (wr_hit && THERMAL) begin
			temp_en_q <= reg_wdata[BIT_TEMP_EN]; // see R7
		end
	end

	// Storage bits standing in for the unused upper field
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			spare_q <= RESET_SPARE;
		end else if (wr_hit && !THERMAL) begin
			spare_q <= reg_wdata[SPARE_LSB +: SPARE_W];
		end
	end

	assign mon_active = THERMAL & temp_en_q;

	// Over-temperature: sticky, cleared only by writing zero, set wins
	assign hot_set = mon_active & hot_sync; // see R8
	assign hot_clr = wr_hit & ~reg_wdata[BIT_OVERTEMP]; // see R9

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hot_q <= RESET_FLAG;
		end else begin
			hot_q <= hot_set | (hot_q & ~hot_clr); // see R13
		end
	end

	// Warning: sticky, cleared by a read of this register, set wins
	assign warn_set = mon_active & warn_sync; // see R10
	assign warn_clr = rd_hit; // see R11

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			warn_q <= RESET_FLAG;
		end else begin
			warn_q <= warn_set | (warn_q & ~warn_clr); // see R11
		end
	end

	// Rising edge of the latched over-temperature flag
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hot_prev_q <= RESET_FLAG;
		end else begin
			hot_prev_q <= hot_q;
		end
	end

	// Read path; read-only bits come from internal state only
	always_comb begin
		if (THERMAL) begin
			upper_bits = {temp_en_q, hot_q, warn_q};
		end else begin
			upper_bits = spare_q;
		end
		read_byte = lbt_pack(upper_bits, headroom_q, code_q); // see R14
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= UNMAPPED_RDATA;
		end else if (reg_rd) begin
			reg_rdata <= addr_hit ? read_byte : UNMAPPED_RDATA; // see R3
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rvalid <= 1'h0;
		end else begin
			reg_rvalid <= reg_rd;
		end
	end

	// Outputs straight from register state
	assign target_voltage_code   = code_q;
	assign temp_monitor_enable   = temp_en_q;
	assign ts_bias_enable        = mon_active;
	assign overtemp_flag         = hot_q;
	assign temp_warning_flag     = warn_q;
	assign regulator_headroom_ok = headroom_q;
	assign rampdown_go           = rampdown_q;
	assign shutdown_req          = hot_q; // see R12
	assign shutdown_pulse        = hot_q & ~hot_prev_q; // see R12

endmodule : lbt_reg

`default_nettype wire

// *** src/lbt_sync.sv ***
// Purpose: Brings asynchronous comparator levels into the clk domain.
// Assumes: Inputs are slow levels from analog comparators or pins.
// Notes:   Three stages; the output follows only when stages two and
//          three agree, so a single-cycle disagreement is held off.
`timescale 1ns/1ns
`default_nettype none

module lbt_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1_q;
	logic [WIDTH-1:0] stage2_q;
	logic [WIDTH-1:0] stage3_q;
	logic [WIDTH-1:0] agree;

	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("lbt_sync needs at least one bit");
		end
	endgenerate

	assign agree = ~(stage2_q ^ stage3_q);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			stage1_q <= '0;
			stage2_q <= '0;
			stage3_q <= '0;
		end else begin
			stage1_q <= async_in;
			stage2_q <= stage1_q;
			stage3_q <= stage2_q;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sync_out <= '0;
		end else begin
			sync_out <= (agree & stage3_q) | (~agree & sync_out);
		end
	end

endmodule : lbt_sync

`default_nettype wire

// *** tb/lbt_chk_assertions.sv ***
// Purpose: Port checker for the boost target and status register.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Bound to every lbt_reg instance.
`timescale 1ns/1ns
`default_nettype none
module lbt_chk (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_rd,
	input wire logic        reg_rvalid,
	input wire logic        cal_done,
	input wire logic [3:0]  cal_code,
	input wire logic        rampdown_go,
	input wire logic [3:0]  target_voltage_code,
	input wire logic [12:0] target_mv,
	input wire logic        temp_monitor_enable,
	input wire logic        overtemp_flag,
	input wire logic        temp_warning_flag,
	input wire logic        regulator_headroom_ok,
	input wire logic        shutdown_req,
	input wire logic        shutdown_pulse
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire logic wr_hit = reg_wr && reg_addr == 8'h06;
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("answer without read");
	a_code_write: assert property (wr_hit && !cal_done |=>
		target_voltage_code == $past(reg_wdata[3:0]))
		else $error("written code not taken");
	a_cal_code: assert property (cal_done |=>
		target_voltage_code == $past(cal_code))
		else $error("calibration code not taken");
	a_mv_map: assert property (target_mv ==
		13'(3825 + 125 * $past(target_voltage_code)))
		else $error("target voltage mapping wrong");
	a_hdr_hold: assert property (!rampdown_go |->
		$stable(regulator_headroom_ok))
		else $error("headroom changed outside strobe end");
	a_hot_latch: assert property (overtemp_flag &&
		!(wr_hit && !reg_wdata[6]) |=> overtemp_flag)
		else $error("hot flag lost");
	a_hot_shutdown: assert property (shutdown_req == overtemp_flag)
		else $error("shutdown not following hot flag");
	a_shutdown_pulse: assert property ($rose(overtemp_flag) |->
		shutdown_pulse)
		else $error("no shutdown pulse");
	a_warn_enable: assert property ($rose(temp_warning_flag) |->
		$past(temp_monitor_enable))
		else $error("warning set while monitor off");
endmodule : lbt_chk
bind lbt_reg lbt_chk u_chk (.*);
`default_nettype wire

// *** tb/lbt_ntc_model.sv ***
// Purpose: Thermistor sense comparators seen by the register.
// Assumes: Sense voltage given in millivolts.
// Notes:   Lower voltage means a hotter LED.
`timescale 1ns/1ns
`default_nettype none
module lbt_ntc_model (
	input  wire logic [12:0] ts_mv,
	output var  logic        ts_below_warn,
	output var  logic        ts_below_hot
);
	assign ts_below_hot  = ts_mv < 13'h159;
	assign ts_below_warn = ts_mv < 13'h41a;
endmodule : lbt_ntc_model
`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for the boost target register.
// Assumes: THERMAL variant, clk at 125 MHz.
// Notes:   Waits of 8 cycles cover the comparator synchroniser.
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic        reg_wr = 1'b0, reg_rd = 1'b0, flash_strobe = 1'b0;
	logic        cal_done = 1'b0, headroom_cmp = 1'b0;
	logic [3:0]  cal_code = 4'h0, target_voltage_code;
	logic [12:0] target_mv, ts_mv = 13'h7d0;
	logic        reg_rvalid, rampdown_go, temp_monitor_enable, ts_bias_enable;
	logic        overtemp_flag, temp_warning_flag, regulator_headroom_ok;
	logic        shutdown_req, shutdown_pulse, ts_below_warn, ts_below_hot;
	int          n_fail = 0, checks_done = 0;
	lbt_reg u_dut (.*);
	lbt_ntc_model u_ntc (.*);
	initial begin
		forever #4 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [12:0] e, g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk("rvalid", 13'h1, 13'(reg_rvalid));
		chk("rdata", 13'(e), 13'(reg_rdata));
	endtask : rd
	task automatic set_ts(input logic [12:0] mv);
		@(posedge clk);
		ts_mv <= mv;
		repeat (8) @(posedge clk);
	endtask : set_ts
	task automatic results;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : results
	initial begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		rd(8'h06, 8'h09);
		chk("mv", 13'h1356, target_mv);
		for (int c = 0; c < 16; c++) begin
			wr(8'h06, 8'(c));
			rd(8'h06, 8'(c));
			chk("mv", 13'(3825 + 125 * c), target_mv);
		end
		wr(8'h06, 8'hff);
		rd(8'h06, 8'h8f);
		chk("tmon", 13'h1, 13'(temp_monitor_enable));
		chk("tsbias", 13'h1, 13'(ts_bias_enable));
		@(posedge clk);
		cal_done <= 1'b1;
		cal_code <= 4'h3;
		@(posedge clk);
		cal_done <= 1'b0;
		rd(8'h06, 8'h83);
		$display("code test done");
		@(posedge clk);
		headroom_cmp <= 1'b1;
		flash_strobe <= 1'b1;
		repeat (6) @(posedge clk);
		flash_strobe <= 1'b0;
		@(posedge clk);
		#1;
		chk("rampdn", 13'h1, 13'(rampdown_go));
		repeat (2) @(posedge clk);
		rd(8'h06, 8'h93);
		@(posedge clk);
		headroom_cmp <= 1'b0;
		repeat (8) @(posedge clk);
		rd(8'h06, 8'h93);
		$display("headroom test done");
		set_ts(13'h320);
		rd(8'h06, 8'hb3);
		set_ts(13'h7d0);
		rd(8'h06, 8'hb3);
		rd(8'h06, 8'h93);
		$display("warning test done");
		set_ts(13'h12c);
		chk("shdn", 13'h1, 13'(shutdown_req));
		set_ts(13'h7d0);
		rd(8'h06, 8'hf3);
		wr(8'h06, 8'h83);
		rd(8'h06, 8'h93);
		wr(8'h07, 8'h00);
		rd(8'h07, 8'h00);
		rd(8'h06, 8'h93);
		$display("hot test done");
		results();
	end
	initial begin
		#20000;
		n_fail++;
		results();
	end
endmodule : testbench
`default_nettype wire
